/* hdl/cmf_pkg.sv */
package cmf_pkg;
  // address spaces seen by a core access
  typedef enum logic [1:0] {CMF_SP_NORMAL, CMF_SP_LONG, CMF_SP_SHORT, CMF_SP_INSTR} cmf_space_t;
  // access widths presented to memory
  typedef enum logic [1:0] {CMF_W16, CMF_W32, CMF_W48, CMF_W64} cmf_width_t;
  // system control register fields
  localparam int          CMF_SYSTEM_CONTROL_REGISTER_VT_BIT    = 2;
  localparam int          CMF_SYSTEM_CONTROL_REGISTER_BW_LSB    = 9;
  localparam int          CMF_NUM_BLOCKS       = 4;
  // mode one register fields
  localparam int          CMF_M1_SECOND_BIT    = 21;
  localparam int          CMF_M1_BC_NINE_BIT   = 22;
  localparam int          CMF_M1_BC_ONE_BIT    = 23;
  localparam int          CMF_M1_SSE_BIT       = 13;
  // mode two register fields
  localparam int          CMF_M2_IOP_DET_BIT   = 20;
  localparam int          CMF_M2_MIS_DET_BIT   = 21;
  // vector table placements
  localparam logic [19:0] CMF_VT_INTERNAL      = 20'h9_0000;
  localparam logic [19:0] CMF_VT_NO_BOOT       = 20'h8_0000;
  // reset values of the control registers
  localparam logic [31:0] CMF_SYSTEM_CONTROL_REGISTER_RST       = 32'h0000_0000;
  localparam logic [31:0] CMF_MODE_ONE_REGISTER_RST        = 32'h0000_0000;
  localparam logic [31:0] CMF_MODE_TWO_REGISTER_RST        = 32'h0000_0000;
  // sticky flag positions
  localparam int          CMF_STKY_IOP_BIT     = 0;
  localparam int          CMF_STKY_MIS_BIT     = 1;
endpackage

/* hdl/cmf_formatter.sv */
`timescale 1ns/1ps
module cmf_formatter
  import cmf_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // control register writes
  input  wire logic              system_control_register_we,
  input  wire logic [31:0]       system_control_register_wdata,
  input  wire logic              mode_one_register_we,
  input  wire logic [31:0]       mode_one_register_wdata,
  input  wire logic              mode_two_register_we,
  input  wire logic [31:0]       mode_two_register_wdata,
  input  wire logic              boot_no_boot,
  // sticky clear, one bit per flag
  input  wire logic [1:0]        sticky_clear,
  // core access request
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire cmf_space_t        acc_space,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic [1:0]        acc_block,
  input  wire logic              force_long_modifier,
  input  wire logic              acc_exchange,
  input  wire logic              acc_iop,
  input  wire logic              acc_dma,
  input  wire logic              acc_index_one,
  input  wire logic              acc_index_nine,
  input  wire logic [3:0]        acc_reg,
  input  wire logic              acc_second,
  // register file store data (named and neighbour)
  input  wire logic [39:0]       reg_rdata_named,
  input  wire logic [39:0]       reg_rdata_pair,
  // memory read data
  input  wire logic [63:0]       mem_rdata,
  // memory side
  output logic                   mem_valid,
  output logic                   mem_write,
  output cmf_width_t             mem_width,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [63:0]            mem_wdata,
  // register file load side
  output logic                   rf_we,
  output logic                   rf_we_pair,
  output logic                   rf_we_other,
  output logic [3:0]             rf_idx,
  output logic [3:0]             rf_idx_pair,
  output logic                   rf_second,
  output logic [39:0]            rf_wdata,
  output logic [39:0]            rf_wdata_pair,
  // mode outputs
  output logic                   second_element_enable,
  output logic [19:0]            vector_table_base,
  output logic                   illegal_input_condition_irq,
  output logic [1:0]             sticky_status_register
);

  // control registers
  logic [31:0] system_control_register_q;
  logic [31:0] mode_one_register_q;
  logic [31:0] mode_two_register_q;
  logic [1:0]  sticky_q;
  logic        irq_q;

  // load context, one copy per pipeline stage, so that the answer is
  // formatted with the width of the access it belongs to
  logic        ld1_q;     // stage one: request stands on the memory bus
  logic        ld2_q;     // stage two: answer stands on mem_rdata
  cmf_width_t  wid1_q;
  cmf_width_t  wid2_q;
  logic        bcast1_q;
  logic        bcast2_q;
  logic [3:0]  ridx1_q;
  logic [3:0]  ridx2_q;
  logic [3:0]  pidx1_q;
  logic [3:0]  pidx2_q;
  logic        sec1_q;
  logic        sec2_q;

  // the forced long path drops the address lsb, so two bits is the floor
  if (ADDR_W < 2) begin : g_addr_w_check
    $error("ADDR_W below 2 cannot hold the pair select bit");
  end

  // decoded control bits
  wire logic                      vector_table_internal_force = system_control_register_q[CMF_SYSTEM_CONTROL_REGISTER_VT_BIT];
  wire logic [CMF_NUM_BLOCKS-1:0] block_word_width_select =
    system_control_register_q[CMF_SYSTEM_CONTROL_REGISTER_BW_LSB +: CMF_NUM_BLOCKS];
  wire logic broadcast_on_index_one  = mode_one_register_q[CMF_M1_BC_ONE_BIT];
  wire logic broadcast_on_index_nine = mode_one_register_q[CMF_M1_BC_NINE_BIT];
  wire logic short_sign_extend       = mode_one_register_q[CMF_M1_SSE_BIT];
  wire logic iop_access_detect_enable      = mode_two_register_q[CMF_M2_IOP_DET_BIT];
  wire logic misaligned_long_detect_enable = mode_two_register_q[CMF_M2_MIS_DET_BIT];

  // forced long applies to normal-word space and to exchange accesses
  wire logic forced  = force_long_modifier && (acc_space == CMF_SP_NORMAL || acc_exchange);
  wire logic blk_wide = block_word_width_select[acc_block];

  // width choice ranked: force, then exchange or fetch, then space, then block bit
  cmf_width_t width;
  always_comb begin
    if (forced) begin
      width = CMF_W64;
    end else if (acc_exchange || acc_space == CMF_SP_INSTR) begin
      width = CMF_W48;
    end else begin
      case (acc_space)
        CMF_SP_LONG:   width = CMF_W64;
        CMF_SP_SHORT:  width = CMF_W16;
        CMF_SP_NORMAL: width = blk_wide ? CMF_W48 : CMF_W32;
        default:       width = CMF_W48;
      endcase
    end
  end

  // neighbour pair: even index named, odd index neighbour
  wire logic [3:0] pair_even = {acc_reg[3:1], 1'b0};
  wire logic [3:0] pair_odd  = {acc_reg[3:1], 1'b1};
  wire logic       long_acc  = (width == CMF_W64);

  // forced long ignores lsb; long space is already 64-bit aligned
  wire logic [ADDR_W-1:0] addr_eff = forced ? {acc_addr[ADDR_W-1:1], 1'b0} : acc_addr;

  // illegal condition detection, DMA accesses excluded from the iop check only
  wire logic ev_mis = acc_valid && forced && acc_addr[0] && misaligned_long_detect_enable;
  wire logic ev_iop = acc_valid && acc_iop && !acc_dma && iop_access_detect_enable;

  // broadcast on loads indexed by the chosen index registers
  wire logic bcast = !acc_write && ((acc_index_one && broadcast_on_index_one) ||
                                    (acc_index_nine && broadcast_on_index_nine));

  // store data formatting
  // narrow widths all start at bit 0, so 16/32/64 mixes at one address line up
  logic [63:0] wdata;
  always_comb begin
    case (width)
      CMF_W64: wdata = {reg_rdata_pair[39:8], reg_rdata_named[39:8]};
      CMF_W48: wdata = {16'h0000, reg_rdata_named, 8'h00};
      CMF_W32: wdata = {32'h0000_0000, reg_rdata_named[39:8]};
      CMF_W16: wdata = {48'h0000_0000_0000, reg_rdata_named[23:8]};
      default: wdata = 64'h0000_0000_0000_0000;
    endcase
  end

  // load data formatting, using the width stored for the answering access
  logic [39:0] ld_named;
  logic [39:0] ld_pair;
  always_comb begin
    ld_pair = {mem_rdata[63:32], 8'h00};
    case (wid2_q)
      CMF_W64: ld_named = {mem_rdata[31:0], 8'h00};
      CMF_W48: ld_named = mem_rdata[47:8];
      CMF_W32: ld_named = {mem_rdata[31:0], 8'h00};
      CMF_W16: ld_named = {{16{short_sign_extend & mem_rdata[15]}}, mem_rdata[15:0], 8'h00};
      default: ld_named = 40'h00_0000_0000;
    endcase
  end

  // control register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control_register_q <= CMF_SYSTEM_CONTROL_REGISTER_RST;
      mode_one_register_q  <= CMF_MODE_ONE_REGISTER_RST;
      mode_two_register_q  <= CMF_MODE_TWO_REGISTER_RST;
    end else begin
      if (system_control_register_we) system_control_register_q <= system_control_register_wdata;
      if (mode_one_register_we)       mode_one_register_q  <= mode_one_register_wdata;
      if (mode_two_register_we)       mode_two_register_q  <= mode_two_register_wdata;
    end
  end

  // set events placed at the sticky flag positions
  wire logic [1:0] sticky_set;
  assign sticky_set[CMF_STKY_IOP_BIT] = ev_iop;
  assign sticky_set[CMF_STKY_MIS_BIT] = ev_mis;

  // sticky flags: a new event wins over a clear in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_sticky
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sticky_q[i] <= 1'b0;
      end else begin
        sticky_q[i] <= sticky_set[i] | (sticky_q[i] & ~sticky_clear[i]);
      end
    end
  end

  // illegal condition pulse, masking is left to the interrupt controller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ev_iop | ev_mis;
    end
  end

  // registered memory request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_width <= CMF_W32;
      mem_addr  <= '0;
      mem_wdata <= 64'h0000_0000_0000_0000;
    end else begin
      mem_valid <= acc_valid;
      mem_write <= acc_write;
      mem_width <= width;
      mem_addr  <= addr_eff;
      mem_wdata <= wdata;
    end
  end

  // load context, stage one: taken with the request; fetches feed the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld1_q    <= 1'b0;
      wid1_q   <= CMF_W32;
      bcast1_q <= 1'b0;
      ridx1_q  <= 4'h0;
      pidx1_q  <= 4'h1;
      sec1_q   <= 1'b0;
    end else begin
      ld1_q    <= acc_valid && !acc_write && (acc_space != CMF_SP_INSTR);
      wid1_q   <= width;
      bcast1_q <= bcast;
      ridx1_q  <= long_acc ? pair_even : acc_reg;
      pidx1_q  <= pair_odd;
      sec1_q   <= acc_second;
    end
  end

  // load context, stage two: lines up with the memory answer on mem_rdata
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld2_q    <= 1'b0;
      wid2_q   <= CMF_W32;
      bcast2_q <= 1'b0;
      ridx2_q  <= 4'h0;
      pidx2_q  <= 4'h1;
      sec2_q   <= 1'b0;
    end else begin
      ld2_q    <= ld1_q;
      wid2_q   <= wid1_q;
      bcast2_q <= bcast1_q;
      ridx2_q  <= ridx1_q;
      pidx2_q  <= pidx1_q;
      sec2_q   <= sec1_q;
    end
  end

  // load outputs taken from memory data in the answer cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_we         <= 1'b0;
      rf_we_pair    <= 1'b0;
      rf_we_other   <= 1'b0;
      rf_idx        <= 4'h0;
      rf_idx_pair   <= 4'h1;
      rf_second     <= 1'b0;
      rf_wdata      <= 40'h00_0000_0000;
      rf_wdata_pair <= 40'h00_0000_0000;
    end else begin
      rf_we         <= ld2_q;
      rf_we_pair    <= ld2_q && (wid2_q == CMF_W64);
      rf_we_other   <= ld2_q && bcast2_q;
      rf_idx        <= ridx2_q;
      rf_idx_pair   <= pidx2_q;
      rf_second     <= sec2_q;
      rf_wdata      <= ld_named;
      rf_wdata_pair <= ld_pair;
    end
  end

  // mode outputs
  assign second_element_enable       = mode_one_register_q[CMF_M1_SECOND_BIT];
  assign vector_table_base           = (vector_table_internal_force || !boot_no_boot) ?
                                       CMF_VT_INTERNAL : CMF_VT_NO_BOOT;
  assign illegal_input_condition_irq = irq_q;
  assign sticky_status_register      = sticky_q;

endmodule

/* tb/cmf_mem_model.sv */
`timescale 1ns/1ps
// memory partner: answers in the cycle after a request
module cmf_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_valid,
  input  wire logic [23:0] mem_addr,
  output logic      [63:0] mem_rdata
);
  // address-tagged word for any requested address, stale bus inverted when no request stands
  always @(posedge clk) begin
    if (mem_valid) begin
      mem_rdata <= {8'hA5, mem_addr, 8'h5A, mem_addr};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* tb/cmf_formatter_assertions.sv */
`timescale 1ns/1ps
module cmf_formatter_assertions
  import cmf_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              system_control_register_we,
  input wire logic [31:0]       system_control_register_wdata,
  input wire logic              acc_valid,
  input wire logic              acc_write,
  input wire cmf_space_t        acc_space,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic              force_long_modifier,
  input wire logic              acc_exchange,
  input wire logic              acc_iop,
  input wire logic              acc_dma,
  input wire logic              mem_valid,
  input wire cmf_width_t        mem_width,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              rf_we,
  input wire logic              rf_we_pair,
  input wire logic [3:0]        rf_idx,
  input wire logic [3:0]        rf_idx_pair,
  input wire logic [19:0]       vector_table_base,
  input wire logic              illegal_input_condition_irq
);
  // all checks share the core clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_MEM_LAT: assert property (acc_valid |=> mem_valid) else $error("no memory request");
  AST_FETCH_48: assert property (acc_valid && acc_space == CMF_SP_INSTR |=> mem_width == CMF_W48)
    else $error("fetch width");
  AST_LONG_64: assert property (acc_valid && acc_space == CMF_SP_LONG |=> mem_width == CMF_W64)
    else $error("long width");
  AST_FORCE_EVEN: assert property (acc_valid && force_long_modifier && acc_space == CMF_SP_NORMAL
    |=> mem_width == CMF_W64 && !mem_addr[0]) else $error("forced long");
  AST_VT_FORCE: assert property (system_control_register_we && system_control_register_wdata[2]
    |=> vector_table_base == CMF_VT_INTERNAL) else $error("vector base");
  AST_IRQ_CAUSE: assert property (illegal_input_condition_irq |-> $past(acc_valid &&
    (acc_iop && !acc_dma || force_long_modifier && acc_addr[0]))) else $error("stray irq");
  AST_LOAD_LAT: assert property (acc_valid && !acc_write && !acc_exchange && acc_space != CMF_SP_INSTR
    |-> ##3 rf_we) else $error("load late");
  AST_PAIR_IDX: assert property (rf_we_pair |-> rf_idx_pair == (rf_idx | 4'h1)) else $error("pair");
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
  import cmf_pkg::*;
;
  logic        clk, rst_n, no_boot, acc_valid, acc_write, force_lw, acc_iop, acc_dma, idx1, idx9, xch, sec;
  logic        mem_valid, mem_write, rf_we, rf_we_pair, rf_we_other, rf_second, sec_en, irq;
  logic [1:0]  sclr, acc_block, sticky;
  logic [2:0]  we;
  logic [3:0]  acc_reg, rf_idx, rf_idx_pair;
  logic [19:0] vtb;
  logic [23:0] acc_addr, mem_addr;
  logic [31:0] wd;
  logic [31:0] regs [3];
  logic [39:0] rf_wdata, rf_wdata_pair;
  logic [63:0] mem_rdata, mem_wdata;
  cmf_space_t  acc_space;
  cmf_width_t  mem_width;
  int          error_cnt = 0, cmp_count = 0;
  cmf_formatter u_dut (.clk(clk), .rst_n(rst_n), .system_control_register_we(we[0]),
    .system_control_register_wdata(wd), .mode_one_register_we(we[1]), .mode_one_register_wdata(wd),
    .mode_two_register_we(we[2]), .mode_two_register_wdata(wd), .boot_no_boot(no_boot), .sticky_clear(sclr),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_block(acc_block), .force_long_modifier(force_lw), .acc_exchange(xch), .acc_iop(acc_iop),
    .acc_dma(acc_dma), .acc_index_one(idx1), .acc_index_nine(idx9), .acc_reg(acc_reg), .acc_second(sec),
    .reg_rdata_named(40'hAB_CDEF_0123), .reg_rdata_pair(40'h12_3456_789A), .mem_rdata(mem_rdata),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_width(mem_width), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .rf_we(rf_we), .rf_we_pair(rf_we_pair), .rf_we_other(rf_we_other),
    .rf_idx(rf_idx), .rf_idx_pair(rf_idx_pair), .rf_second(rf_second),
    .rf_wdata(rf_wdata), .rf_wdata_pair(rf_wdata_pair), .second_element_enable(sec_en),
    .vector_table_base(vtb), .illegal_input_condition_irq(irq), .sticky_status_register(sticky));
  cmf_mem_model u_mem (.clk(clk), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // control register write: 0 system, 1 mode one, 2 mode two
  task automatic wr(input int r, input logic [31:0] d);
    @(negedge clk);
    we = 3'(1 << r);
    wd = d;
    regs[r] = d;
    @(negedge clk);
    we = 3'h0;
  endtask
  // one core access, judged at the memory side and at the register side
  task automatic acc(input cmf_space_t sp, input logic [23:0] a, input logic [1:0] blk, input logic f,
                     input logic w, input cmf_width_t ew);
    logic [23:0] ma;
    logic [63:0] d;
    logic [39:0] e;
    ma = (f && sp == CMF_SP_NORMAL) ? {a[23:1], 1'h0} : a;
    d = {8'hA5, ma, 8'h5A, ma};
    @(negedge clk);
    acc_space = sp;
    acc_addr = a;
    acc_block = blk;
    force_lw = f;
    acc_write = w;
    acc_valid = 1'h1;
    @(negedge clk);
    acc_valid = 1'h0;
    chk(mem_width, ew);
    chk(mem_write, w);
    chk(mem_addr, ma);
    chk(irq, (regs[2][21] && ma != a) || (regs[2][20] && acc_iop && !acc_dma));
    if (w) chk(mem_wdata[31:0], 32'hABCD_EF01);
    repeat (2) @(negedge clk);
    case (ew)
      CMF_W16: e = {{16{regs[1][13] & d[15]}}, d[15:0], 8'h00};
      CMF_W48: e = d[47:8];
      default: e = {d[31:0], 8'h00};
    endcase
    chk(rf_we, !w && sp != CMF_SP_INSTR);
    if (!w && sp != CMF_SP_INSTR) begin
      chk(rf_wdata, e);
      chk(rf_we_other, (regs[1][23] & idx1) | (regs[1][22] & idx9));
      chk(rf_we_pair, ew == CMF_W64);
      chk(rf_idx, (ew == CMF_W64) ? acc_reg & 4'hE : acc_reg);
      chk(rf_second, sec);
      if (ew == CMF_W64) chk({rf_idx_pair, rf_wdata_pair}, {acc_reg | 4'h1, d[63:32], 8'h00});
    end
  endtask
  // vector placement and element enable
  task automatic t_modes();
    no_boot = 1'h1;
    wr(0, 32'h0000_0000);
    chk(vtb, CMF_VT_NO_BOOT);
    wr(0, 32'h0000_0404);
    chk(vtb, CMF_VT_INTERNAL);
    wr(1, 32'h0020_0000);
    chk(sec_en, 1'h1);
  endtask
  // width per access kind, block 1 wide
  task automatic t_widths();
    acc_reg = 4'h7;
    acc(CMF_SP_INSTR, 24'h00_0100, 2'h0, 1'h0, 1'h0, CMF_W48);
    acc(CMF_SP_NORMAL, 24'h00_0101, 2'h0, 1'h0, 1'h0, CMF_W32);
    acc(CMF_SP_NORMAL, 24'h00_0104, 2'h1, 1'h0, 1'h0, CMF_W48);
    acc(CMF_SP_NORMAL, 24'h00_0103, 2'h1, 1'h1, 1'h0, CMF_W64);
    acc(CMF_SP_LONG, 24'h00_0105, 2'h1, 1'h0, 1'h0, CMF_W64);
    acc(CMF_SP_NORMAL, 24'h00_0106, 2'h0, 1'h0, 1'h1, CMF_W32);
  endtask
  // short loads with both extension settings, then two broadcast loads
  task automatic t_mode_one();
    wr(1, 32'h0000_2000);
    acc(CMF_SP_SHORT, 24'h00_8123, 2'h0, 1'h0, 1'h0, CMF_W16);
    wr(1, 32'h0080_0000);
    acc(CMF_SP_SHORT, 24'h00_8123, 2'h0, 1'h0, 1'h0, CMF_W16);
    idx1 = 1'h1;
    acc(CMF_SP_NORMAL, 24'h00_0110, 2'h0, 1'h0, 1'h0, CMF_W32);
    idx1 = 1'h0;
    idx9 = 1'h1;
    wr(1, 32'h0040_0000);
    acc(CMF_SP_NORMAL, 24'h00_0111, 2'h0, 1'h0, 1'h0, CMF_W32);
    idx9 = 1'h0;
    xch = 1'h1;
    sec = 1'h1;
    acc(CMF_SP_NORMAL, 24'h00_0112, 2'h0, 1'h0, 1'h0, CMF_W48);
    acc(CMF_SP_NORMAL, 24'h00_0114, 2'h0, 1'h1, 1'h0, CMF_W64);
    xch = 1'h0;
    sec = 1'h0;
  endtask
  // illegal access detection and sticky flags
  task automatic t_detect();
    wr(2, 32'h0030_0000);
    acc(CMF_SP_NORMAL, 24'h00_0201, 2'h0, 1'h1, 1'h0, CMF_W64);
    chk(sticky, 2'h2);
    acc_iop = 1'h1;
    acc_dma = 1'h1;
    acc(CMF_SP_NORMAL, 24'h00_0202, 2'h0, 1'h0, 1'h0, CMF_W32);
    acc_dma = 1'h0;
    acc(CMF_SP_NORMAL, 24'h00_0202, 2'h0, 1'h0, 1'h0, CMF_W32);
    chk(sticky, 2'h3);
    sclr = 2'h3;
    @(negedge clk);
    sclr = 2'h0;
    chk(sticky, 2'h0);
    wr(2, 32'h0000_0000);
    acc(CMF_SP_NORMAL, 24'h00_0203, 2'h0, 1'h1, 1'h0, CMF_W64);
    acc_iop = 1'h0;
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end
  initial begin
    {rst_n, no_boot, acc_valid, acc_write, force_lw, acc_iop, acc_dma, idx1, idx9, xch, sec, sclr, we, wd} = '0;
    {acc_block, acc_reg, acc_addr} = '0;
    acc_space = CMF_SP_NORMAL;
    regs = '{default: 32'h0000_0000};
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    t_modes();
    t_widths();
    t_mode_one();
    t_detect();
    test_done();
  end
endmodule
bind cmf_formatter cmf_formatter_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .system_control_register_we(system_control_register_we), .acc_valid(acc_valid), .acc_write(acc_write),
  .system_control_register_wdata(system_control_register_wdata), .acc_space(acc_space), .acc_addr(acc_addr),
  .force_long_modifier(force_long_modifier), .acc_exchange(acc_exchange), .acc_iop(acc_iop), .acc_dma(acc_dma),
  .mem_valid(mem_valid), .mem_width(mem_width), .mem_addr(mem_addr), .rf_we(rf_we), .rf_we_pair(rf_we_pair),
  .rf_idx(rf_idx), .rf_idx_pair(rf_idx_pair), .vector_table_base(vector_table_base),
  .illegal_input_condition_irq(illegal_input_condition_irq));
